// >>> panel_frame_model.sv
`timescale 1ns/10ps
module panel_frame_model #(
   parameter int FRAME_CYC = 30
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic update_req,
   output logic vblank,
   output logic screen_update,
   output logic ram_power_on
);
   int cnt;
   // a short frame keeps the sixty-frame timeout test cheap
   always @(posedge core_clk) begin
      if (rst) begin
         cnt <= 0;
         vblank <= 1'b0;
         screen_update <= 1'b0;
         ram_power_on <= 1'b0;
      end else begin
         cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
         vblank <= (cnt == FRAME_CYC - 1);
         screen_update <= update_req;
         // frame RAM power flips each frame so the status bit is seen both ways
         if (cnt == FRAME_CYC - 1) begin
            ram_power_on <= ~ram_power_on;
         end
      end
   end
endmodule

// >>> psr2_selective_update_control_bench.sv
`timescale 1ns/10ps
module psr2_selective_update_control_bench;
   import su_ctl_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   reg_req_t reg_req = '0;
   logic update_req = 1'b0;
   logic [31:0] reg_rdata, seed, w, r;
   logic reg_rvalid, vblank, screen_update, ram_power_on, sr_enabled, su_active;
   logic deep_sleep, train_active, full_fetch, include_line_count, include_y_valid, exp18;
   logic [3:0] io_wake_lines, fast_wake_lines, block_lines;
   int n_fail = 0;
   int check_count = 0;
   int cnt;
   su_ctl #(.TP2_500US(20), .TP2_100US(8), .TP2_2500US(40), .TP2_50US(4)) su_ctl_i (
      .core_clk(core_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .vblank(vblank), .screen_update(screen_update),
      .ram_power_on(ram_power_on), .sr_enabled(sr_enabled), .su_active(su_active),
      .deep_sleep(deep_sleep), .train_active(train_active), .full_fetch(full_fetch),
      .include_line_count(include_line_count), .include_y_valid(include_y_valid),
      .io_wake_lines(io_wake_lines), .fast_wake_lines(fast_wake_lines),
      .block_lines(block_lines));
   panel_frame_model panel_frame_model_i (.core_clk(core_clk), .rst(rst),
      .update_req(update_req), .vblank(vblank), .screen_update(screen_update),
      .ram_power_on(ram_power_on));
   initial forever #2 core_clk = ~core_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // bits 30 and 18 never take write data; 18 mirrors the RAM power level
   function automatic logic [31:0] exp_word(input logic [31:0] d, input logic p);
      return (d & 32'hBFFBFFFF) | ({31'h0, p} << 18);
   endfunction
   // scaled training lengths, the same ones handed to the design instance
   function automatic logic [31:0] exp_train(input logic [1:0] code);
      case (code)
         2'b00: return 32'd20;
         2'b01: return 32'd8;
         2'b10: return 32'd40;
         default: return 32'd4;
      endcase
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [31:0] d);
      reg_req.wr_en = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(posedge core_clk);
      #1;
      reg_req.wr_en = 1'b0;
      @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [23:0] a, output logic [31:0] d);
      reg_req.rd_en = 1'b1;
      reg_req.addr = a;
      // the power level only moves at an edge, so this is what the next edge samples
      exp18 = ram_power_on;
      @(posedge core_clk);
      #1;
      reg_req.rd_en = 1'b0;
      chk("rvalid", 32'h1, reg_rvalid);
      d = reg_rdata;
      @(posedge core_clk);
      #1;
   endtask
   task automatic vbs(input int n);
      repeat (n) begin
         do begin
            @(posedge core_clk);
            #1;
         end while (vblank !== 1'b1);
      end
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      $display("mismatch watchdog expected done seen hang");
      print_verdict();
   end
   initial begin
      seed = 32'h000012D2;
      repeat (12) @(posedge core_clk);
      #1;
      rst = 1'b0;
      rd(SU_CTL_OFFSET, r);
      chk("reset word", exp_word(32'h00004811, exp18), r);
      chk("io wake", 32'h7, io_wake_lines);
      chk("fast wake", 32'h7, fast_wake_lines);
      chk("y valid", 32'h1, include_y_valid);
      $display("test reset done");
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         w = seed & 32'h7FFFFFFF;
         if (i == 0) w = 32'h7FFFFFFF;
         if (i == 1) w = 32'h00000000;
         if (w[12]) w[28] = 1'b1;
         if (w[7:5] == 3'h0) w[5] = 1'b1;
         wr(SU_CTL_OFFSET, w);
         rd(SU_CTL_OFFSET, r);
         chk("readback", exp_word(w, exp18), r);
         chk("line count", {31'h0, w[25]}, include_line_count);
         chk("y valid", {31'h0, ~w[26]}, include_y_valid);
         chk("io wake", w[15:13] + 32'h5, io_wake_lines);
         chk("fast wake", w[12:10] + 32'h5, fast_wake_lines);
         chk("block", w[28] ? 32'hC : 32'h8, block_lines);
      end
      wr(24'h060904, 32'hFFFFFFFF);
      rd(24'h060904, r);
      chk("unmapped", 32'h0, r);
      rd(SU_CTL_OFFSET, r);
      chk("untouched", exp_word(w, exp18), r);
      $display("test registers done");
      wr(SU_CTL_OFFSET, 32'h00100120);
      wr(SU_CTL_OFFSET, 32'h80100120);
      vbs(1);
      chk("enabled", 32'h1, sr_enabled);
      vbs(1);
      chk("early entry", 32'h0, su_active);
      vbs(1);
      chk("entered", 32'h1, su_active);
      cnt = 0;
      for (int k = 0; k < 3000 && full_fetch !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
         if (vblank === 1'b1) cnt++;
      end
      chk("fetch frames", 32'd60, cnt);
      chk("no sleep", 32'h0, deep_sleep);
      $display("test entry and fetch done");
      wr(SU_CTL_OFFSET, 32'h00100120);
      vbs(1);
      chk("disabled", 32'h0, sr_enabled);
      chk("left update", 32'h0, su_active);
      for (int c = 0; c < 4; c++) begin
         // fields change only while disabled; idle count 2, entry 2
         w = 32'h00100022;
         w[9:8] = c[1:0];
         wr(SU_CTL_OFFSET, w);
         w[31] = 1'b1;
         wr(SU_CTL_OFFSET, w);
         vbs(3);
         chk("entered", 32'h1, su_active);
         wr(SU_CTL_OFFSET, w);
         repeat (2) @(posedge core_clk);
         #1;
         chk("still in update", 32'h1, su_active);
         vbs(2);
         chk("deep sleep", 32'h1, deep_sleep);
         update_req = 1'b1;
         @(posedge core_clk);
         #1;
         update_req = 1'b0;
         cnt = 0;
         while (train_active !== 1'b1 && cnt < 10) begin
            @(posedge core_clk);
            #1;
            cnt++;
         end
         cnt = 0;
         while (train_active === 1'b1 && cnt < 100) begin
            @(posedge core_clk);
            #1;
            cnt++;
         end
         chk("train cycles", exp_train(w[9:8]), cnt);
         chk("back in update", 32'h1, su_active);
         w[31] = 1'b0;
         wr(SU_CTL_OFFSET, w);
         vbs(1);
         chk("disabled", 32'h0, sr_enabled);
         chk("left update", 32'h0, su_active);
      end
      $display("test frame flow done");
      print_verdict();
   end
endmodule

// >>> su_ctl.sv
`timescale 1ns/10ps
module su_ctl #(
   parameter int CNT_W = 20,
   parameter int TP2_500US = su_ctl_pkg::TP2_500US_CYC,
   parameter int TP2_100US = su_ctl_pkg::TP2_100US_CYC,
   parameter int TP2_2500US = su_ctl_pkg::TP2_2500US_CYC,
   parameter int TP2_50US = su_ctl_pkg::TP2_50US_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire su_ctl_pkg::reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic vblank,
   input wire logic screen_update,
   input wire logic ram_power_on,
   output logic sr_enabled,
   output logic su_active,
   output logic deep_sleep,
   output logic train_active,
   output logic full_fetch,
   output logic include_line_count,
   output logic include_y_valid,
   output logic [3:0] io_wake_lines,
   output logic [3:0] fast_wake_lines,
   output logic [3:0] block_lines
);
   import su_ctl_pkg::*;

   typedef struct packed {
      selective_update_control_t cfg;
      su_state_t fsm;
      logic applied_en;
      logic [3:0] entry_cnt;
      logic [3:0] idle_cnt;
      logic [11:0] fetch_cnt;
      logic [CNT_W-1:0] train_cnt;
      logic [31:0] rdata;
      logic rvalid;
      logic full_fetch;
      logic inc_count;
      logic inc_y;
      logic [3:0] io_lines;
      logic [3:0] fw_lines;
      logic [3:0] blk_lines;
      logic su_out;
      logic deep_out;
      logic train_out;
   } state_t;

   state_t st_q;
   state_t st_d;
   logic hit;
   logic [31:0] cfg_bits;
   logic [3:0] entry_need;
   logic [11:0] fetch_limit;
   logic [CNT_W-1:0] train_len;

   assign hit = (reg_req.addr == SU_CTL_OFFSET);
   assign cfg_bits = st_q.cfg;

   always_comb begin
      entry_need = (st_q.cfg.entry_frame_count < MIN_ENTRY_FRAMES) ?
         MIN_ENTRY_FRAMES : st_q.cfg.entry_frame_count;
      fetch_limit = 12'(st_q.cfg.full_fetch_timeout * FETCH_STEP_FRAMES);
      case (st_q.cfg.pattern2_train_time)
         2'b00: train_len = CNT_W'(TP2_500US);
         2'b01: train_len = CNT_W'(TP2_100US);
         2'b10: train_len = CNT_W'(TP2_2500US);
         default: train_len = CNT_W'(TP2_50US);
      endcase
   end

   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      st_d.full_fetch = 1'b0;
      if (reg_req.wr_en && hit) begin
         // bit 18 and bit 30 keep their stored zero; a write here only stores fields
         st_d.cfg = (reg_req.wdata & SU_CTL_WR_MASK) |
            (cfg_bits & ~SU_CTL_WR_MASK);
      end
      if (reg_req.rd_en) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = 32'h00000000;
         if (hit) begin
            st_d.rdata = cfg_bits;
            st_d.rdata[RAM_PWR_BIT] = ram_power_on;
         end
      end
      st_d.inc_count = st_q.cfg.include_line_count;
      st_d.inc_y = ~st_q.cfg.omit_y_valid;
      st_d.io_lines = {1'b0, st_q.cfg.io_wake} + WAKE_LINE_BASE;
      st_d.fw_lines = {1'b0, st_q.cfg.fast_wake} + WAKE_LINE_BASE;
      // fast wake of 9-12 lines is only sound with the 12-line block count
      st_d.blk_lines = st_q.cfg.block_count_sel ? BLOCK_LINES_3 : BLOCK_LINES_2;
      if (vblank) begin
         st_d.applied_en = st_q.cfg.enable;
      end
      case (st_q.fsm)
         ST_OFF: begin
            if (vblank && st_q.cfg.enable) begin
               st_d.fsm = ST_ENTRY;
               st_d.entry_cnt = 4'h0;
            end
         end
         ST_ENTRY: begin
            if (vblank) begin
               st_d.entry_cnt = st_q.entry_cnt + 4'h1;
               if (st_q.entry_cnt + 4'h1 >= entry_need) begin
                  st_d.fsm = ST_SU;
                  st_d.idle_cnt = 4'h0;
                  st_d.fetch_cnt = 12'h000;
               end
            end
         end
         ST_SU: begin
            if (screen_update) begin
               st_d.idle_cnt = 4'h0;
            end else if (vblank) begin
               st_d.idle_cnt = st_q.idle_cnt + 4'h1;
               if (st_q.cfg.idle_frames != 4'h0 &&
                   st_q.idle_cnt + 4'h1 >= st_q.cfg.idle_frames) begin
                  st_d.fsm = ST_DEEP;
               end
            end
         end
         ST_DEEP: begin
            if (screen_update) begin
               st_d.fsm = ST_TRAIN;
               st_d.train_cnt = train_len;
            end
         end
         ST_TRAIN: begin
            st_d.train_cnt = st_q.train_cnt - CNT_W'(1);
            if (st_q.train_cnt <= CNT_W'(1)) begin
               st_d.fsm = ST_SU;
               st_d.idle_cnt = 4'h0;
            end
         end
         default: st_d.fsm = ST_OFF;
      endcase
      if (st_q.fsm == ST_SU && vblank) begin
         if (st_q.cfg.full_fetch_timeout != 5'h00) begin
            st_d.fetch_cnt = st_q.fetch_cnt + 12'h001;
            if (st_q.fetch_cnt + 12'h001 >= fetch_limit) begin
               st_d.full_fetch = 1'b1;
               st_d.fetch_cnt = 12'h000;
            end
         end
      end
      if (vblank && !st_q.cfg.enable) begin
         st_d.fsm = ST_OFF;
      end
      // state flags are registered with the state so the outputs leave a flip-flop
      st_d.su_out = (st_d.fsm == ST_SU);
      st_d.deep_out = (st_d.fsm == ST_DEEP);
      st_d.train_out = (st_d.fsm == ST_TRAIN);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.cfg <= SU_CTL_RESET;
         st_q.fsm <= ST_OFF;
         st_q.inc_y <= 1'b1;
         st_q.io_lines <= 4'h7;
         st_q.fw_lines <= 4'h7;
         st_q.blk_lines <= BLOCK_LINES_2;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign reg_rvalid = st_q.rvalid;
   assign sr_enabled = st_q.applied_en;
   assign su_active = st_q.su_out;
   assign deep_sleep = st_q.deep_out;
   assign train_active = st_q.train_out;
   assign full_fetch = st_q.full_fetch;
   assign include_line_count = st_q.inc_count;
   assign include_y_valid = st_q.inc_y;
   assign io_wake_lines = st_q.io_lines;
   assign fast_wake_lines = st_q.fw_lines;
   assign block_lines = st_q.blk_lines;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   AST_RAM_BIT_READ: assert property (
      reg_req.rd_en && hit |=> reg_rvalid && reg_rdata[RAM_PWR_BIT] == $past(ram_power_on))
      else $error("ram power bit not reported");
   AST_IO_WAKE: assert property (
      ##1 io_wake_lines == {1'b0, $past(st_q.cfg.io_wake)} + WAKE_LINE_BASE)
      else $error("io wake lines wrong");
   AST_FAST_WAKE: assert property (
      ##1 fast_wake_lines == {1'b0, $past(st_q.cfg.fast_wake)} + WAKE_LINE_BASE)
      else $error("fast wake lines wrong");
   AST_BLOCK: assert property (
      ##1 block_lines == ($past(st_q.cfg.block_count_sel) ? BLOCK_LINES_3 : BLOCK_LINES_2))
      else $error("block lines wrong");
   AST_LINE_COUNT: assert property (
      ##1 include_line_count == $past(st_q.cfg.include_line_count) &&
      include_y_valid == !$past(st_q.cfg.omit_y_valid))
      else $error("packet options not applied");
   AST_EN_AT_VBLANK: assert property (
      $changed(sr_enabled) |-> $past(vblank))
      else $error("enable applied outside vblank");
   AST_NO_FETCH_ZERO: assert property (
      full_fetch |-> $past(st_q.cfg.full_fetch_timeout) != 5'h00)
      else $error("full fetch with timeout off");
   AST_DEEP_ENTRY: assert property (
      $rose(deep_sleep) |-> $past(st_q.cfg.idle_frames) != 4'h0 && $past(vblank))
      else $error("deep sleep entered wrongly");
   AST_WRITE_NO_EXIT: assert property (
      su_active && reg_req.wr_en && !vblank && !screen_update |=> su_active)
      else $error("register write left update state");
   AST_SU_ENTRY: assert property (
      $rose(su_active) && $past(st_q.fsm) == ST_ENTRY |-> $past(vblank) &&
      $past(st_q.entry_cnt) + 4'h1 >= 4'h2)
      else $error("entered update too early");

   COV_DEEP: cover property ($rose(deep_sleep));
   COV_FETCH: cover property (full_fetch);
   COV_TRAIN_DONE: cover property ($fell(train_active) && su_active);
endmodule

// >>> su_ctl_pkg.sv
// How it works
// - bit 26 set drops Y-valid indication
// - bit 25 set adds line count
// - bits 24:20 timeout in sixty-frame steps
// - zero timeout never forces full fetch
// - bit 18 read-only frame RAM power
// - IO buffer wake lines are code plus 5
// - fast wake lines are code plus 5
// - bits 9:8 select pattern-2 training time
// - bits 7:4 frames before update entry, at least 2
// - bits 3:0 idle frames, zero disables sleep
// - idle field write never exits or updates
// - enable bit applied at next vblank
// - bit 28 selects 8 or 12 lines
package su_ctl_pkg;
   localparam logic [23:0] SU_CTL_OFFSET = 24'h060900;
   localparam logic [31:0] SU_CTL_RESET = 32'h00004811;
   localparam logic [31:0] SU_CTL_WR_MASK = 32'hBFFBFFFF;
   localparam int RAM_PWR_BIT = 18;
   localparam logic [3:0] WAKE_LINE_BASE = 4'h5;
   localparam logic [3:0] BLOCK_LINES_2 = 4'h8;
   localparam logic [3:0] BLOCK_LINES_3 = 4'hC;
   localparam logic [5:0] FETCH_STEP_FRAMES = 6'h3C;
   localparam logic [3:0] MIN_ENTRY_FRAMES = 4'h2;
   localparam int CLK_PERIOD_NS = 4;
   localparam int TP2_500US_NS = 500000;
   localparam int TP2_100US_NS = 100000;
   localparam int TP2_2500US_NS = 2500000;
   localparam int TP2_50US_NS = 50000;
   localparam int TP2_500US_CYC = TP2_500US_NS / CLK_PERIOD_NS;
   localparam int TP2_100US_CYC = TP2_100US_NS / CLK_PERIOD_NS;
   localparam int TP2_2500US_CYC = TP2_2500US_NS / CLK_PERIOD_NS;
   localparam int TP2_50US_CYC = TP2_50US_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic enable;
      logic rsvd30;
      logic deep_restore;
      logic block_count_sel;
      logic frame_sync_aux;
      logic omit_y_valid;
      logic include_line_count;
      logic [4:0] full_fetch_timeout;
      logic rsvd19;
      logic ram_power;
      logic [1:0] rsvd17;
      logic [2:0] io_wake;
      logic [2:0] fast_wake;
      logic [1:0] pattern2_train_time;
      logic [3:0] entry_frame_count;
      logic [3:0] idle_frames;
   } selective_update_control_t;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [23:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   typedef enum {ST_OFF, ST_ENTRY, ST_SU, ST_DEEP, ST_TRAIN} su_state_t;
endpackage
